/* src/fgp_gpio_port.sv */
// four-bit general-purpose port: registers, pin drive and pin sensing
`include "fgp_map.svh"
`default_nettype none

module fgp_gpio_port (
	// clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rst,
	// register port
	input  wire logic [`FGP_ADDR_W-1:0]   reg_addr,
	input  wire logic [`FGP_DATA_W-1:0]   reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [`FGP_DATA_W-1:0]   reg_rdata,
	// pins, sensed at both thresholds
	input  wire logic [`FGP_PINS-1:0]     pin_st_in,
	input  wire logic [`FGP_PINS-1:0]     pin_ttl_in,
	// pins, driven
	output logic      [`FGP_PINS-1:0]     pin_out,
	output logic      [`FGP_PINS-1:0]     pin_oe,
	output logic      [`FGP_PINS-1:0]     pin_pullup_en,
	output logic      [`FGP_PINS-1:0]     pin_analog_en,
	// peripheral side
	input  wire logic [`FGP_PERIPH_N-1:0] periph_out,
	output logic      [`FGP_PINS-1:0]     pin_level,
	output logic      [`FGP_PINS-1:0]     pin_change
);

	// control registers
	logic [`FGP_PINS-1:0]   dir_q;
	logic [`FGP_PINS-1:0]   dir_d;
	logic [`FGP_PINS-1:0]   latch_q;
	logic [`FGP_PINS-1:0]   latch_d;
	logic [`FGP_PINS-1:0]   thr_q;
	logic [`FGP_PINS-1:0]   thr_d;
	logic [`FGP_PINS-1:0]   wpu_q;
	logic [`FGP_PINS-1:0]   wpu_d;
	logic [`FGP_PINS-1:0]   ana_q;
	logic [`FGP_PINS-1:0]   ana_d;
	logic [`FGP_DATA_W-1:0] psel_q;
	logic [`FGP_DATA_W-1:0] psel_d;
	logic [`FGP_PINS-1:0]   rise_en_q;
	logic [`FGP_PINS-1:0]   rise_en_d;
	logic [`FGP_PINS-1:0]   fall_en_q;
	logic [`FGP_PINS-1:0]   fall_en_d;
	logic [`FGP_PINS-1:0]   chg_flag_q;
	logic [`FGP_PINS-1:0]   chg_flag_d;
	logic [`FGP_PINS-1:0]   prev_lvl_q;
	logic [`FGP_DATA_W-1:0] rdata_d;

	// synchronised pin levels
	logic [`FGP_PINS-1:0]   st_sync;
	logic [`FGP_PINS-1:0]   ttl_sync;

	// per-pin cell results
	logic [`FGP_PINS-1:0]   cell_level;
	logic [`FGP_PINS-1:0]   cell_drive;
	logic [`FGP_PINS-1:0]   cell_enable;

	// address decode
	logic                   wr_pin_state;
	logic                   wr_direction;
	logic                   wr_latch;
	logic                   wr_threshold;
	logic                   wr_pullup;
	logic                   wr_analog;
	logic                   wr_psel;
	logic                   wr_bit_set;
	logic                   wr_bit_clr;
	logic                   wr_chg_rise;
	logic                   wr_chg_fall;
	logic                   wr_chg_flag;
	logic [`FGP_PINS-1:0]   wdata_pins;

	// change detection
	logic [`FGP_PINS-1:0]   rise_seen;
	logic [`FGP_PINS-1:0]   fall_seen;
	logic [`FGP_PINS-1:0]   chg_event;
	logic [`FGP_PINS-1:0]   chg_clear;

	// read selection
	logic [`FGP_PINS-1:0]   rd_pins;
	logic                   rd_mapped;

	fgp_sync #(
		.WIDTH(`FGP_PINS)
	) u_sync_st (
		.mclk    (mclk),
		.rst     (rst),
		.async_in(pin_st_in),
		.sync_out(st_sync)
	);

	fgp_sync #(
		.WIDTH(`FGP_PINS)
	) u_sync_ttl (
		.mclk    (mclk),
		.rst     (rst),
		.async_in(pin_ttl_in),
		.sync_out(ttl_sync)
	);

	for (genvar i = 0; i < `FGP_PINS; i++) begin : g_pin
		fgp_pin_cell u_cell (
			.st_level  (st_sync[i]),
			.ttl_level (ttl_sync[i]),
			.thr_sel   (fgp_pkg::fgp_thr_type'(thr_q[i])),
			.analog    (ana_q[i]),
			.dir_in    (dir_q[i]),
			.src_sel   (fgp_pkg::fgp_src_type'(psel_q[2*i+1 -: `FGP_PSEL_W])),
			.latch_bit (latch_q[i]),
			.periph_out(periph_out),
			.level     (cell_level[i]),
			.drive     (cell_drive[i]),
			.enable    (cell_enable[i])
		);
	end

	// write decode
	assign wdata_pins   = reg_wdata[`FGP_PIN_MSB:`FGP_PIN_LSB];
	assign wr_pin_state = reg_wr && (reg_addr == `FGP_OFF_PIN_STATE);
	assign wr_direction = reg_wr && (reg_addr == `FGP_OFF_DIRECTION);
	assign wr_latch     = reg_wr && (reg_addr == `FGP_OFF_LATCH);
	assign wr_threshold = reg_wr && (reg_addr == `FGP_OFF_THRESHOLD);
	assign wr_pullup    = reg_wr && (reg_addr == `FGP_OFF_PULLUP);
	assign wr_analog    = reg_wr && (reg_addr == `FGP_OFF_ANALOG);
	assign wr_psel      = reg_wr && (reg_addr == `FGP_OFF_PSEL);
	assign wr_bit_set   = reg_wr && (reg_addr == `FGP_OFF_BIT_SET);
	assign wr_bit_clr   = reg_wr && (reg_addr == `FGP_OFF_BIT_CLR);
	assign wr_chg_rise  = reg_wr && (reg_addr == `FGP_OFF_CHG_RISE);
	assign wr_chg_fall  = reg_wr && (reg_addr == `FGP_OFF_CHG_FALL);
	assign wr_chg_flag  = reg_wr && (reg_addr == `FGP_OFF_CHG_FLAG);

	assign latch_d = wr_pin_state ? wdata_pins :
	                 wr_bit_set   ? (cell_level | wdata_pins) :
	                 wr_bit_clr   ? (cell_level & ~wdata_pins) :
	                 wr_latch     ? wdata_pins : latch_q;

	assign dir_d = wr_direction ? wdata_pins : dir_q;

	assign thr_d = wr_threshold ? wdata_pins : thr_q;

	assign wpu_d = wr_pullup ? wdata_pins : wpu_q;

	assign ana_d = wr_analog ? wdata_pins : ana_q;

	assign psel_d = wr_psel ? reg_wdata[`FGP_PSEL_MSB:`FGP_PSEL_LSB] : psel_q;

	assign rise_en_d = wr_chg_rise ? wdata_pins : rise_en_q;
	assign fall_en_d = wr_chg_fall ? wdata_pins : fall_en_q;

	assign rise_seen = cell_level & ~prev_lvl_q & rise_en_q;
	assign fall_seen = ~cell_level & prev_lvl_q & fall_en_q;
	assign chg_event = rise_seen | fall_seen;

	// flags clear on write of one, a new event wins
	assign chg_clear  = wr_chg_flag ? wdata_pins : '0;
	assign chg_flag_d = (chg_flag_q & ~chg_clear) | chg_event;

	always_comb begin
		rd_mapped = 1'b1;
		unique case (reg_addr)
			`FGP_OFF_PIN_STATE: rd_pins = cell_level;
			`FGP_OFF_DIRECTION: rd_pins = dir_q;
			`FGP_OFF_LATCH:     rd_pins = latch_q;
			`FGP_OFF_THRESHOLD: rd_pins = thr_q;
			`FGP_OFF_PULLUP:    rd_pins = wpu_q;
			`FGP_OFF_ANALOG:    rd_pins = ana_q;
			`FGP_OFF_CHG_RISE:  rd_pins = rise_en_q;
			`FGP_OFF_CHG_FALL:  rd_pins = fall_en_q;
			`FGP_OFF_CHG_FLAG:  rd_pins = chg_flag_q;
			default: begin
				rd_pins   = '0;
				rd_mapped = (reg_addr == `FGP_OFF_PSEL);
			end
		endcase
	end

	// read data for the next cycle only
	assign rdata_d = !reg_rd                       ? `FGP_RST_RDATA :
	                 (reg_addr == `FGP_OFF_PSEL)   ? psel_q :
	                 rd_mapped                     ? {{(`FGP_DATA_W-`FGP_PINS){1'b0}}, rd_pins} :
	                 `FGP_RST_RDATA;

	// direction register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dir_q <= `FGP_RST_DIRECTION;
		end else begin
			dir_q <= dir_d;
		end
	end

	// output latch
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			latch_q <= `FGP_RST_LATCH;
		end else begin
			latch_q <= latch_d;
		end
	end

	// threshold register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			thr_q <= `FGP_RST_THRESHOLD;
		end else begin
			thr_q <= thr_d;
		end
	end

	// pull-up register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wpu_q <= `FGP_RST_PULLUP;
		end else begin
			wpu_q <= wpu_d;
		end
	end

	// analog register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ana_q <= `FGP_RST_ANALOG;
		end else begin
			ana_q <= ana_d;
		end
	end

	// source select register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			psel_q <= `FGP_RST_PSEL;
		end else begin
			psel_q <= psel_d;
		end
	end

	// rise enable register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rise_en_q <= `FGP_RST_CHG;
		end else begin
			rise_en_q <= rise_en_d;
		end
	end

	// fall enable register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fall_en_q <= `FGP_RST_CHG;
		end else begin
			fall_en_q <= fall_en_d;
		end
	end

	// previous level for edges
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prev_lvl_q <= `FGP_RST_CHG;
		end else begin
			prev_lvl_q <= cell_level;
		end
	end

	// sticky change flags
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			chg_flag_q <= `FGP_RST_CHG;
		end else begin
			chg_flag_q <= chg_flag_d;
		end
	end

	// one-cycle change pulse
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_change <= `FGP_RST_CHG;
		end else begin
			pin_change <= chg_event;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_out <= `FGP_RST_LATCH;
			pin_oe  <= ~`FGP_RST_DIRECTION;
		end else begin
			pin_out <= cell_drive;
			pin_oe  <= cell_enable;
		end
	end

	// pull-up and analog outputs
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_pullup_en <= `FGP_RST_PULLUP;
			pin_analog_en <= `FGP_RST_ANALOG;
		end else begin
			pin_pullup_en <= wpu_q;
			pin_analog_en <= ana_q;
		end
	end

	// sensed levels
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_level <= `FGP_RST_CHG;
		end else begin
			pin_level <= cell_level;
		end
	end

	// register reads
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata <= `FGP_RST_RDATA;
		end else begin
			reg_rdata <= rdata_d;
		end
	end

endmodule

`default_nettype wire

/* src/fgp_map.svh */
// register offsets, field layout, reset values and widths of the four-bit gpio port
`ifndef FGP_MAP_SVH
`define FGP_MAP_SVH

// bus widths and pin count
`define FGP_ADDR_W 4
`define FGP_DATA_W 8
`define FGP_PINS 4
`define FGP_PSEL_W 2
`define FGP_PERIPH_N 3

// register offsets
`define FGP_OFF_PIN_STATE 4'h0
`define FGP_OFF_DIRECTION 4'h1
`define FGP_OFF_LATCH 4'h2
`define FGP_OFF_THRESHOLD 4'h3
`define FGP_OFF_PULLUP 4'h4
`define FGP_OFF_ANALOG 4'h5
`define FGP_OFF_PSEL 4'h6
`define FGP_OFF_BIT_SET 4'h7
`define FGP_OFF_BIT_CLR 4'h8
`define FGP_OFF_CHG_RISE 4'h9
`define FGP_OFF_CHG_FALL 4'ha
`define FGP_OFF_CHG_FLAG 4'hb

// field positions
`define FGP_PIN_LSB 0
`define FGP_PIN_MSB 3
`define FGP_PSEL_LSB 0
`define FGP_PSEL_MSB 7

// reset values
`define FGP_RST_DIRECTION 4'hf
`define FGP_RST_LATCH 4'h0
`define FGP_RST_THRESHOLD 4'hf
`define FGP_RST_PULLUP 4'h0
`define FGP_RST_ANALOG 4'h0
`define FGP_RST_PSEL 8'h00
`define FGP_RST_CHG 4'h0
`define FGP_RST_RDATA 8'h00

`endif

/* src/fgp_pin_cell.sv */
// one pin: input threshold choice and output source choice
`include "fgp_map.svh"
`default_nettype none

module fgp_pin_cell (
	// sensed levels, already synchronised
	input  wire logic                     st_level,
	input  wire logic                     ttl_level,
	// controls
	input  wire fgp_pkg::fgp_thr_type     thr_sel,
	input  wire logic                     analog,
	input  wire logic                     dir_in,
	input  wire fgp_pkg::fgp_src_type     src_sel,
	// output sources
	input  wire logic                     latch_bit,
	input  wire logic [`FGP_PERIPH_N-1:0] periph_out,
	// results
	output wire logic                     level,
	output wire logic                     drive,
	output wire logic                     enable
);

	logic src_bit;

	// threshold picks the read level, analog mode reads zero
	assign level = analog ? 1'b0 : ((thr_sel == fgp_pkg::FGP_THR_SCHMITT) ? st_level : ttl_level);

	always_comb begin
		unique case (src_sel)
			fgp_pkg::FGP_SRC_LATCH:   src_bit = latch_bit;
			fgp_pkg::FGP_SRC_PERIPH0: src_bit = periph_out[0];
			fgp_pkg::FGP_SRC_PERIPH1: src_bit = periph_out[1];
			fgp_pkg::FGP_SRC_PERIPH2: src_bit = periph_out[2];
		endcase
	end

	// digital drive ignores analog mode
	assign drive  = src_bit;
	assign enable = ~dir_in;

endmodule

`default_nettype wire

/* src/fgp_pkg.sv */
// types shared by the four-bit gpio port
`default_nettype none

package fgp_pkg;

	// output source of one pin
	typedef enum logic [1:0] {
		FGP_SRC_LATCH   = 2'h0,
		FGP_SRC_PERIPH0 = 2'h1,
		FGP_SRC_PERIPH1 = 2'h2,
		FGP_SRC_PERIPH2 = 2'h3
	} fgp_src_type;

	// input threshold of one pin
	typedef enum logic {
		FGP_THR_TTL     = 1'h0,
		FGP_THR_SCHMITT = 1'h1
	} fgp_thr_type;

endpackage

`default_nettype wire

/* src/fgp_sync.sv */
// two-stage synchroniser for pin levels
`default_nettype none

module fgp_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

`default_nettype wire

/* test/fgp_gpio_port_assertions.sv */
// concurrent checks on the four-bit gpio port
`include "fgp_map.svh"
`default_nettype none

module fgp_gpio_port_checker (
	// clock and reset
	input wire logic       mclk,
	input wire logic       rst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// pins
	input wire logic [3:0] pin_st_in,
	input wire logic [3:0] pin_ttl_in,
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	input wire logic [3:0] pin_pullup_en,
	input wire logic [3:0] pin_analog_en,
	input wire logic [3:0] pin_level,
	input wire logic [3:0] pin_change
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_dir_wr;
		reg_wr && reg_addr == `FGP_OFF_DIRECTION;
	endsequence

	property p_mirror(logic [3:0] off, logic [3:0] o);
		logic [3:0] v;
		(reg_wr && reg_addr == off, v = reg_wdata[3:0]) |-> ##2 o == v;
	endproperty

	a_rdata_idle: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
		else $error("read data outside read slot");
	a_unmapped_zero: assert property (reg_rd && reg_addr >= 4'hc |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_dir_drive: assert property (s_dir_wr |-> ##2 pin_oe == ~$past(reg_wdata[3:0], 2))
		else $error("enable does not follow direction");
	a_oe_cause: assert property ($changed(pin_oe) |-> $past(reg_wr && reg_addr == `FGP_OFF_DIRECTION, 2))
		else $error("enable moved without direction write");
	a_pullup_follow: assert property (p_mirror(`FGP_OFF_PULLUP, pin_pullup_en))
		else $error("pull-up enable not updated");
	a_analog_follow: assert property (p_mirror(`FGP_OFF_ANALOG, pin_analog_en))
		else $error("analog enable not updated");
	a_level_cause: assert property ((pin_level & ~$past(pin_level)
		& ~($past(pin_st_in, 3) | $past(pin_ttl_in, 3))) == 4'h0)
		else $error("level rose without pin input");
	a_change_cause: assert property ((pin_change & ~((pin_level ^ $past(pin_level))
		| ($past(pin_level) ^ $past(pin_level, 2)))) == 4'h0)
		else $error("change pulse without level change");
	a_reset_quiet: assert property ($fell(rst) |-> pin_out == 4'h0 && pin_oe == 4'h0 && reg_rdata == 8'h00)
		else $error("outputs not idle after reset");
endmodule

bind fgp_gpio_port fgp_gpio_port_checker u_fgp_gpio_port_checker (.mclk(mclk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .pin_st_in(pin_st_in), .pin_ttl_in(pin_ttl_in), .pin_out(pin_out),
	.pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .pin_analog_en(pin_analog_en),
	.pin_level(pin_level), .pin_change(pin_change));

`default_nettype wire

/* test/fgp_pin_board.sv */
// board model: pin wire levels at both thresholds
`default_nettype none

module fgp_pin_board (
	// clock
	input wire logic        mclk,
	// device drive
	input wire logic  [3:0] pin_out,
	input wire logic  [3:0] pin_oe,
	input wire logic  [3:0] pin_pullup_en,
	// outside drive
	input wire logic  [3:0] ext_en,
	input wire logic  [3:0] ext_val,
	input wire logic  [3:0] ttl_flip,
	// sensed levels
	output logic      [3:0] pin_st_in,
	output logic      [3:0] pin_ttl_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] flt_q = 4'h5;
	logic [3:0] lvl;

	// floating pins wander each cycle
	always_ff @(posedge mclk) flt_q <= ~flt_q;
	assign lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & (pin_pullup_en | flt_q));
	assign pin_st_in = lvl;
	assign pin_ttl_in = lvl ^ ttl_flip;
endmodule

`default_nettype wire

/* test/tb_four_bit_gpio_port.sv */
// self-checking bench of the four-bit gpio port
`include "fgp_map.svh"
`default_nettype none

module tb_four_bit_gpio_port;
	timeunit 1ns;
	timeprecision 1ps;
	logic       mclk, rst, reg_wr, reg_rd;
	logic [3:0] reg_addr, pin_st_in, pin_ttl_in, pin_out, pin_oe;
	logic [3:0] pin_pullup_en, pin_analog_en, pin_level, pin_change, ext_val, ttl_flip, ext_en;
	logic [7:0] reg_wdata, reg_rdata;
	logic [2:0] periph_out;
	int         err_total, total_checks;

	fgp_gpio_port u_fgp_gpio_port (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_st_in(pin_st_in),
		.pin_ttl_in(pin_ttl_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
		.pin_analog_en(pin_analog_en), .periph_out(periph_out), .pin_level(pin_level),
		.pin_change(pin_change));
	fgp_pin_board u_fgp_pin_board (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup_en(pin_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .ttl_flip(ttl_flip),
		.pin_st_in(pin_st_in), .pin_ttl_in(pin_ttl_in));

	task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(n, reg_rdata, exp);
	endtask

	task automatic settle;
		repeat (6) @(posedge mclk);
		#1;
	endtask

	task automatic watch(output logic [3:0] seen);
		seen = 4'h0;
		repeat (6) begin
			@(posedge mclk);
			#1 seen = seen | pin_change;
		end
	endtask

	task automatic end_of_test;
		if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic t_reset;
		rchk("dir", `FGP_OFF_DIRECTION, 8'h0f);
		rchk("thr", `FGP_OFF_THRESHOLD, 8'h0f);
		rchk("psel", `FGP_OFF_PSEL, 8'h00);
		wr(4'hc, 8'hff);
		rchk("unmapped", 4'hc, 8'h00);
		wr(`FGP_OFF_PULLUP, 8'h05);
		settle;
		chk("pullup", {4'h0, pin_pullup_en}, 8'h05);
		chk("pulled", {4'h0, pin_level & 4'h5}, 8'h05);
		@(posedge mclk);
		#1 chk("pulled_next", {4'h0, pin_level & 4'h5}, 8'h05);
		rchk("pullup_rd", `FGP_OFF_PULLUP, 8'h05);
		ext_en <= 4'hf;
	endtask

	task automatic t_drive;
		wr(`FGP_OFF_DIRECTION, 8'h00);
		wr(`FGP_OFF_PIN_STATE, 8'h0a);
		settle;
		chk("oe", {4'h0, pin_oe}, 8'h0f);
		chk("out", {4'h0, pin_out}, 8'h0a);
		rchk("pins", `FGP_OFF_PIN_STATE, 8'h0a);
		rchk("latch", `FGP_OFF_LATCH, 8'h0a);
	endtask

	task automatic t_input;
		ext_val <= 4'h5;
		wr(`FGP_OFF_DIRECTION, 8'h0f);
		settle;
		chk("oe_off", {4'h0, pin_oe}, 8'h00);
		rchk("pins_in", `FGP_OFF_PIN_STATE, 8'h05);
		rchk("latch_kept", `FGP_OFF_LATCH, 8'h0a);
	endtask

	task automatic t_rmw;
		ext_val <= 4'h1;
		wr(`FGP_OFF_DIRECTION, 8'h03);
		settle;
		wr(`FGP_OFF_BIT_SET, 8'h04);
		settle;
		rchk("set", `FGP_OFF_LATCH, 8'h0d);
		chk("set_out", {4'h0, pin_out & pin_oe}, 8'h0c);
		wr(`FGP_OFF_BIT_CLR, 8'h08);
		settle;
		rchk("clr", `FGP_OFF_LATCH, 8'h05);
	endtask

	task automatic t_thr;
		logic [3:0] seen;
		ext_val <= 4'hf;
		wr(`FGP_OFF_DIRECTION, 8'h0f);
		wr(`FGP_OFF_CHG_RISE, 8'h0f);
		wr(`FGP_OFF_CHG_FALL, 8'h0f);
		settle;
		wr(`FGP_OFF_CHG_FLAG, 8'h0f);
		ttl_flip <= 4'h3;
		wr(`FGP_OFF_THRESHOLD, 8'h00);
		settle;
		chk("level_ttl", {4'h0, pin_level}, 8'h0c);
		rchk("ttl", `FGP_OFF_PIN_STATE, 8'h0c);
		rchk("flags", `FGP_OFF_CHG_FLAG, 8'h03);
		wr(`FGP_OFF_THRESHOLD, 8'h0f);
		watch(seen);
		chk("change", {4'h0, seen}, 8'h03);
		rchk("schmitt", `FGP_OFF_PIN_STATE, 8'h0f);
	endtask

	task automatic t_psel;
		wr(`FGP_OFF_DIRECTION, 8'h00);
		wr(`FGP_OFF_PIN_STATE, 8'h00);
		periph_out <= 3'b101;
		wr(`FGP_OFF_PSEL, 8'h0d);
		settle;
		chk("psel_out", {4'h0, pin_out}, 8'h03);
		wr(`FGP_OFF_ANALOG, 8'h0f);
		settle;
		chk("analog_out", {4'h0, pin_out}, 8'h03);
		chk("analog_en", {4'h0, pin_analog_en}, 8'h0f);
		rchk("analog_rd", `FGP_OFF_PIN_STATE, 8'h00);
		wr(`FGP_OFF_LATCH, 8'h0c);
		settle;
		chk("latch_out", {4'h0, pin_out}, 8'h0f);
	endtask

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial begin
		repeat (3000) @(posedge mclk);
		err_total++;
		end_of_test;
	end

	initial begin
		rst = 1'b1;
		{reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{periph_out, ext_val, ttl_flip, ext_en} = '0;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		t_reset;
		t_drive;
		t_input;
		t_rmw;
		t_thr;
		t_psel;
		end_of_test;
	end
endmodule

`default_nettype wire
